// ---- t8w_consts.svh ----
// Constants of the 8-bit timer with waveform modes: offsets, fields, resets, limits.
// Assumes inclusion by bare name from the package and the timer module.
`ifndef T8W_CONSTS_SVH
`define T8W_CONSTS_SVH

// ==========================================================================
// Register offsets
`define T8W_ADDR_W 3
`define T8W_OFS_CTRL 3'h0
`define T8W_OFS_COUNT 3'h1
`define T8W_OFS_COMPARE 3'h2
`define T8W_OFS_FLAGS 3'h3
`define T8W_OFS_PORT 3'h4
`define T8W_OFS_STATUS 3'h5

// ==========================================================================
// Field positions
`define T8W_CTRL_FORCE_BIT 7
`define T8W_FLAG_CMP_BIT 0
`define T8W_FLAG_OVF_BIT 1
`define T8W_PORT_DIR_BIT 0
`define T8W_PORT_DATA_BIT 1
`define T8W_STAT_WAVE_BIT 0
`define T8W_STAT_DOWN_BIT 1

// ==========================================================================
// Reset values and counter limits
`define T8W_CTRL_RST 7'h00
`define T8W_BYTE_RST 8'h00
`define T8W_BOTTOM 8'h00
`define T8W_MAX 8'hFF
`define T8W_PRESC_W 10

// ==========================================================================
// Prescaler taps: low bits that must all be one for a divided tick
`define T8W_DIV8_BITS 3
`define T8W_DIV64_BITS 6
`define T8W_DIV256_BITS 8
`define T8W_DIV1024_BITS 10

`endif

// ---- t8w_pkg.sv ----
// Types shared by the 8-bit timer with waveform modes.
// Assumes the constants header sits in the same folder.
`include "t8w_consts.svh"

package t8w_pkg;

    // ======================================================================
    // Waveform modes, in the order of their select codes
    typedef enum logic [1:0] {
        T8W_MODE_NORMAL,
        T8W_MODE_PHASE,
        T8W_MODE_CLEAR,
        T8W_MODE_FAST
    } t8w_wave_mode_t;

    // ======================================================================
    // Control register image, high bits first in the byte
    typedef struct packed {
        logic [2:0] clk_sel;
        logic [1:0] out_mode_sel;
        t8w_wave_mode_t wave_mode_sel;
    } t8w_ctrl_t;

    // ======================================================================
    // One register bus request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [`T8W_ADDR_W-1:0] addr;
        logic [7:0] wdata;
    } t8w_bus_req_t;

endpackage

// ---- t8w_timer.sv ----
// 8-bit timer/counter with clear-on-compare, fast PWM and phase-correct PWM.
// Assumes a plain register port on clk_sys and an asynchronous external count pin.
//
// Contract
// - Mode 2 clears count_value when it equals compare_value.
// - Clear-on-compare sets compare_flag each time the count reaches top.
// - Clear-on-compare writes act at once; a passed match waits for wrap.
// - Clear-on-compare with out mode 1 toggles wave_out on each match.
// - The pin shows the waveform only while its direction is output.
// - Tick is clock divided by 1, 8, 64, 256 or 1024.
// - Clear-on-compare sets overflow_flag on the tick from maximum to zero.
// - Mode 3 counts bottom to maximum, then clears on the next tick.
// - Fast PWM sets overflow_flag each time the count reaches maximum.
// - Fast PWM out mode 2 clears on match, sets at wrap; 3 inverts.
// - Fast PWM period is 256 ticks.
// - Fast PWM extremes: bottom gives one-tick spike, maximum a constant level.
// - Fast PWM out mode 1 toggles on match, compare still double buffered.
// - Mode 1 counts up then down, one tick at maximum per turn.
// - Phase-correct resolution is fixed at eight bits.
// - Phase-correct out mode 2 clears on up match, sets on down; 3 inverts.
// - Phase-correct sets overflow_flag at bottom, not at maximum.
// - Phase-correct period is 510 ticks.
// - Phase-correct extremes: bottom holds low, maximum holds high, inverted opposite.
// - Fully synchronous counter; tick is only a clock enable.
// - PWM modes load compare_value from a buffer at top; others immediately.
// - A match sets compare_flag on the next tick.
// - Out mode 0 leaves wave_out untouched at matches.
//
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/100ps
`include "t8w_consts.svh"

module t8w_timer (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Register port
    input wire t8w_pkg::t8w_bus_req_t bus_req,
    output logic [7:0] rdata,
    // External count source pin
    input wire logic ext_count_pin,
    // Waveform pin and flags
    output logic pin_out,
    output logic pin_oe,
    output logic compare_flag,
    output logic overflow_flag
);

    // ======================================================================
    // State
    t8w_pkg::t8w_ctrl_t ctrl_reg, ctrl_next;
    logic [7:0] count_value_reg, count_value_next;
    logic [7:0] compare_buf_reg, compare_buf_next;
    logic [7:0] compare_value_reg, compare_value_next;
    logic [`T8W_PRESC_W-1:0] presc_reg, presc_next;
    logic count_down_reg, count_down_next;
    logic block_reg, block_next;
    logic wave_out_reg, wave_out_next;
    logic cmp_flag_reg, cmp_flag_next;
    logic ovf_flag_reg, ovf_flag_next;
    logic pin_dir_reg, pin_dir_next;
    logic port_data_reg, port_data_next;
    logic pin_out_reg, pin_out_next;
    logic pin_oe_reg, pin_oe_next;
    logic [7:0] rdata_reg, rdata_next;
    logic ext_sync1_reg, ext_sync2_reg, ext_prev_reg;

    // ======================================================================
    // External pin synchroniser; only the second stage feeds the edge detect.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ext_sync1_reg <= 1'b0;
            ext_sync2_reg <= 1'b0;
            ext_prev_reg <= 1'b0;
        end else begin
            ext_sync1_reg <= ext_count_pin;
            ext_sync2_reg <= ext_sync1_reg;
            ext_prev_reg <= ext_sync2_reg;
        end
    end

    // ======================================================================
    // Next-state logic
    logic tick;
    logic match;
    logic at_max;
    logic pwm_mode;
    logic cmp_set;
    logic ovf_set;
    logic force_hit;

    always_comb begin
        ctrl_next = ctrl_reg;
        count_value_next = count_value_reg;
        compare_buf_next = compare_buf_reg;
        compare_value_next = compare_value_reg;
        count_down_next = count_down_reg;
        block_next = block_reg;
        wave_out_next = wave_out_reg;
        pin_dir_next = pin_dir_reg;
        port_data_next = port_data_reg;
        cmp_set = 1'b0;
        ovf_set = 1'b0;
        force_hit = 1'b0;
        presc_next = presc_reg + `T8W_PRESC_W'(1);

        // Every divided rate is a one-cycle enable, never a derived clock.
        unique case (ctrl_reg.clk_sel)
            3'h0: tick = 1'b0;
            3'h1: tick = 1'b1;
            3'h2: tick = &presc_reg[`T8W_DIV8_BITS-1:0];
            3'h3: tick = &presc_reg[`T8W_DIV64_BITS-1:0];
            3'h4: tick = &presc_reg[`T8W_DIV256_BITS-1:0];
            3'h5: tick = &presc_reg[`T8W_DIV1024_BITS-1:0];
            3'h6: tick = ext_prev_reg & ~ext_sync2_reg;
            3'h7: tick = ~ext_prev_reg & ext_sync2_reg;
        endcase

        pwm_mode = ctrl_reg.wave_mode_sel == t8w_pkg::T8W_MODE_PHASE ||
                   ctrl_reg.wave_mode_sel == t8w_pkg::T8W_MODE_FAST;
        at_max = count_value_reg == `T8W_MAX;
        // A count write hides the match for one tick.
        match = (count_value_reg == compare_value_reg) && !block_reg;

        if (tick) begin
            block_next = 1'b0;
            cmp_set = match;
            unique case (ctrl_reg.wave_mode_sel)
                t8w_pkg::T8W_MODE_NORMAL: begin
                    count_value_next = count_value_reg + 8'h01;
                    ovf_set = at_max;
                    if (match) begin
                        unique case (ctrl_reg.out_mode_sel)
                            2'h0: wave_out_next = wave_out_reg;
                            2'h1: wave_out_next = ~wave_out_reg;
                            2'h2: wave_out_next = 1'b0;
                            2'h3: wave_out_next = 1'b1;
                        endcase
                    end
                end
                t8w_pkg::T8W_MODE_CLEAR: begin
                    // Compare below the count misses; the count runs on to wrap.
                    count_value_next = match ? `T8W_BOTTOM : count_value_reg + 8'h01;
                    ovf_set = at_max;
                    if (match) begin
                        unique case (ctrl_reg.out_mode_sel)
                            2'h0: wave_out_next = wave_out_reg;
                            2'h1: wave_out_next = ~wave_out_reg;
                            2'h2: wave_out_next = 1'b0;
                            2'h3: wave_out_next = 1'b1;
                        endcase
                    end
                end
                t8w_pkg::T8W_MODE_FAST: begin
                    // Wrap after maximum gives 256 ticks a period.
                    count_value_next = at_max ? `T8W_BOTTOM : count_value_reg + 8'h01;
                    ovf_set = at_max;
                    if (match && ctrl_reg.out_mode_sel == 2'h1) begin
                        wave_out_next = ~wave_out_reg;
                    end else if (ctrl_reg.out_mode_sel[1]) begin
                        // At maximum the wrap action wins over the match.
                        if (at_max) begin
                            wave_out_next = ~ctrl_reg.out_mode_sel[0];
                        end else if (match) begin
                            wave_out_next = ctrl_reg.out_mode_sel[0];
                        end
                    end
                    if (at_max) begin
                        compare_value_next = compare_buf_reg;
                    end
                end
                t8w_pkg::T8W_MODE_PHASE: begin
                    // Full 8-bit slope both ways: 255 up plus 255 down.
                    if (at_max) begin
                        count_down_next = 1'b1;
                        count_value_next = `T8W_MAX - 8'h01;
                        compare_value_next = compare_buf_reg;
                    end else if (count_value_reg == `T8W_BOTTOM) begin
                        count_down_next = 1'b0;
                        count_value_next = `T8W_BOTTOM + 8'h01;
                        ovf_set = 1'b1;
                    end else if (count_down_reg) begin
                        count_value_next = count_value_reg - 8'h01;
                    end else begin
                        count_value_next = count_value_reg + 8'h01;
                    end
                    if (ctrl_reg.out_mode_sel[1]) begin
                        if (at_max && compare_value_reg == `T8W_MAX) begin
                            wave_out_next = ~ctrl_reg.out_mode_sel[0];
                        end else if (match) begin
                            // Bottom and maximum both count as up-counting.
                            wave_out_next = (count_down_reg && !at_max &&
                                             count_value_reg != `T8W_BOTTOM) ^
                                            ctrl_reg.out_mode_sel[0];
                        end
                    end
                end
            endcase
        end

        // Software access comes last so a write overrides the same-cycle tick.
        if (bus_req.wr) begin
            unique case (bus_req.addr)
                `T8W_OFS_CTRL: begin
                    ctrl_next = t8w_pkg::t8w_ctrl_t'(bus_req.wdata[6:0]);
                    force_hit = bus_req.wdata[`T8W_CTRL_FORCE_BIT] && !pwm_mode;
                end
                `T8W_OFS_COUNT: begin
                    count_value_next = bus_req.wdata;
                    block_next = 1'b1;
                end
                `T8W_OFS_COMPARE: begin
                    compare_buf_next = bus_req.wdata;
                    if (!pwm_mode) begin
                        compare_value_next = bus_req.wdata;
                    end
                end
                `T8W_OFS_PORT: begin
                    pin_dir_next = bus_req.wdata[`T8W_PORT_DIR_BIT];
                    port_data_next = bus_req.wdata[`T8W_PORT_DATA_BIT];
                end
                default: ;
            endcase
        end

        // A forced match acts on the waveform only, without flag or clear.
        if (force_hit) begin
            unique case (bus_req.wdata[3:2])
                2'h0: wave_out_next = wave_out_reg;
                2'h1: wave_out_next = ~wave_out_reg;
                2'h2: wave_out_next = 1'b0;
                2'h3: wave_out_next = 1'b1;
            endcase
        end

        // Write one to clear; a set in the same cycle wins.
        cmp_flag_next = cmp_flag_reg | cmp_set;
        ovf_flag_next = ovf_flag_reg | ovf_set;
        if (bus_req.wr && bus_req.addr == `T8W_OFS_FLAGS) begin
            cmp_flag_next = (cmp_flag_reg & ~bus_req.wdata[`T8W_FLAG_CMP_BIT]) | cmp_set;
            ovf_flag_next = (ovf_flag_reg & ~bus_req.wdata[`T8W_FLAG_OVF_BIT]) | ovf_set;
        end

        // The waveform replaces port data while an out mode is chosen.
        pin_oe_next = pin_dir_next;
        pin_out_next = (ctrl_next.out_mode_sel != 2'h0) ? wave_out_next : port_data_next;

        rdata_next = 8'h00;
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                `T8W_OFS_CTRL: rdata_next = {1'b0, ctrl_reg};
                `T8W_OFS_COUNT: rdata_next = count_value_reg;
                `T8W_OFS_COMPARE: rdata_next = compare_buf_reg;
                `T8W_OFS_FLAGS: rdata_next = {6'h00, ovf_flag_reg, cmp_flag_reg};
                `T8W_OFS_PORT: rdata_next = {6'h00, port_data_reg, pin_dir_reg};
                `T8W_OFS_STATUS: rdata_next = {6'h00, count_down_reg, wave_out_reg};
                default: rdata_next = 8'h00;
            endcase
        end
    end

    // ======================================================================
    // Registers
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ctrl_reg <= t8w_pkg::t8w_ctrl_t'(`T8W_CTRL_RST);
            count_value_reg <= `T8W_BYTE_RST;
            compare_buf_reg <= `T8W_BYTE_RST;
            compare_value_reg <= `T8W_BYTE_RST;
            presc_reg <= '0;
            count_down_reg <= 1'b0;
            block_reg <= 1'b0;
            wave_out_reg <= 1'b0;
            cmp_flag_reg <= 1'b0;
            ovf_flag_reg <= 1'b0;
            pin_dir_reg <= 1'b0;
            port_data_reg <= 1'b0;
            pin_out_reg <= 1'b0;
            pin_oe_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            ctrl_reg <= ctrl_next;
            count_value_reg <= count_value_next;
            compare_buf_reg <= compare_buf_next;
            compare_value_reg <= compare_value_next;
            presc_reg <= presc_next;
            count_down_reg <= count_down_next;
            block_reg <= block_next;
            wave_out_reg <= wave_out_next;
            cmp_flag_reg <= cmp_flag_next;
            ovf_flag_reg <= ovf_flag_next;
            pin_dir_reg <= pin_dir_next;
            port_data_reg <= port_data_next;
            pin_out_reg <= pin_out_next;
            pin_oe_reg <= pin_oe_next;
            rdata_reg <= rdata_next;
        end
    end

    assign rdata = rdata_reg;
    assign pin_out = pin_out_reg;
    assign pin_oe = pin_oe_reg;
    assign compare_flag = cmp_flag_reg;
    assign overflow_flag = ovf_flag_reg;

endmodule

// ---- t8w_timer_props.sv ----
// Port checker for the 8-bit timer with waveform modes.
// Assumes one 200 MHz clk_sys and the bind at the foot of this file.
`timescale 1ns/100ps
module t8w_props (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Register port
    input wire t8w_pkg::t8w_bus_req_t bus_req,
    input wire logic [7:0] rdata,
    // Pin and flags
    input wire logic pin_out,
    input wire logic pin_oe,
    input wire logic compare_flag,
    input wire logic overflow_flag
);
    // ======================================================================
    // Shadows of the written settings and cycle gaps between pin edges.
    t8w_pkg::t8w_ctrl_t ctrl_reg;
    logic [7:0] cmp_reg;
    logic [15:0] age_reg, gap_reg, rise_reg;
    logic last_reg, cfg_ok, coc, pwm, wr_ctrl, wr_port, wr_flag;
    assign wr_ctrl = bus_req.wr && bus_req.addr == 3'h0;
    assign wr_flag = bus_req.wr && bus_req.addr == 3'h3;
    assign wr_port = bus_req.wr && bus_req.addr == 3'h4;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ctrl_reg <= '0;
            cmp_reg <= 8'h00;
            age_reg <= 16'h0000;
            gap_reg <= 16'h0000;
            rise_reg <= 16'h0000;
            last_reg <= 1'b0;
        end else begin
            if (wr_ctrl) ctrl_reg <= bus_req.wdata[6:0];
            if (bus_req.wr && bus_req.addr == 3'h2) cmp_reg <= bus_req.wdata;
            age_reg <= (bus_req.wr && bus_req.addr <= 3'h2) ? 16'h0000 : age_reg + 16'h0001;
            gap_reg <= (pin_out != last_reg) ? 16'h0001 : gap_reg + 16'h0001;
            rise_reg <= (pin_out && !last_reg) ? 16'h0001 : rise_reg + 16'h0001;
            last_reg <= pin_out;
        end
    end
    // Period checks wait until a setting has outlived the buffer load and one period.
    assign cfg_ok = age_reg > 16'h05DC && ctrl_reg.clk_sel == 3'h1;
    assign coc = cfg_ok && ctrl_reg.wave_mode_sel[1] && !ctrl_reg.wave_mode_sel[0];
    assign pwm = cfg_ok && ctrl_reg.wave_mode_sel[0] && ctrl_reg.out_mode_sel[1];
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_rd_answer: assert property (!$past(bus_req.rd) |-> rdata == 8'h00)
        else $error("read data outside the answer cycle");
    a_dir_write: assert property (!$stable(pin_oe) |-> $past(wr_port))
        else $error("pin drive changed without a port write");
    a_cmp_clear: assert property ($fell(compare_flag) |-> $past(wr_flag) && $past(bus_req.wdata[0]))
        else $error("compare flag fell without a clear");
    a_ovf_clear: assert property ($fell(overflow_flag) |-> $past(wr_flag) && $past(bus_req.wdata[1]))
        else $error("overflow flag fell without a clear");
    a_stop_quiet: assert property ($rose(compare_flag) || $rose(overflow_flag)
        |-> $past(ctrl_reg.clk_sel) != 3'h0) else $error("flag set while stopped");
    a_port_hold: assert property (!$stable(pin_out) && $past(ctrl_reg.out_mode_sel) == 2'h0
        |-> $past(wr_port) || $past(wr_ctrl)) else $error("pin moved with output mode 0");
    a_coc_toggle: assert property ($changed(pin_out) && coc && ctrl_reg.out_mode_sel == 2'h1
        |-> gap_reg == {8'h00, cmp_reg} + 16'h0001) else $error("toggle half period wrong");
    a_pwm_period: assert property ($rose(pin_out) && pwm
        |-> rise_reg == (ctrl_reg.wave_mode_sel[1] ? 16'h0100 : 16'h01FE))
        else $error("pwm period wrong");
    a_ovf_wrap: assert property ($rose(overflow_flag) && pwm && ctrl_reg.wave_mode_sel[1]
        && !ctrl_reg.out_mode_sel[0] && cmp_reg != 8'hFF |-> $rose(pin_out))
        else $error("overflow not at wrap set");
endmodule
bind t8w_timer t8w_props u_props (.clk_sys(clk_sys), .reset(reset), .bus_req(bus_req),
    .rdata(rdata), .pin_out(pin_out), .pin_oe(pin_oe), .compare_flag(compare_flag),
    .overflow_flag(overflow_flag));

// ---- t8w_load.sv ----
// External load on the waveform pin: a pull-down and a high-time counter.
// Assumes the bench holds count_en low for a cycle between windows.
`timescale 1ns/100ps
module t8w_load (
    // Clock
    clk_sys,
    // Pin from the timer
    pin_out,
    pin_oe,
    // Measurement
    count_en,
    pin_level,
    high_cnt
);
    input wire logic clk_sys;
    input wire logic pin_out;
    input wire logic pin_oe;
    input wire logic count_en;
    output logic pin_level;
    output logic [15:0] high_cnt;
    // A released pin falls to the pull-down, so it never counts as high.
    assign pin_level = pin_oe ? pin_out : 1'b0;
    always @(posedge clk_sys) begin
        if (!count_en) begin
            high_cnt <= 16'h0000;
        end else if (pin_level) begin
            high_cnt <= high_cnt + 16'h0001;
        end
    end
endmodule

// ---- t8w_timer_tb.sv ----
// Self-checking bench for the 8-bit timer with waveform modes.
// Assumes the checker is bound into the timer and the load model sits on the pin.
`timescale 1ns/100ps
module t8w_timer_tb;
    // ======================================================================
    // Stimulus, outputs and score.
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic ext_count_pin = 1'b0;
    logic count_en = 1'b0;
    t8w_pkg::t8w_bus_req_t bus_req = '0;
    logic [7:0] rdata;
    logic [7:0] rd_val;
    logic pin_out, pin_oe, compare_flag, overflow_flag, pin_level;
    logic [15:0] high_cnt;
    int err_total = 0;
    int n_tests = 0;
    logic [7:0] m_ctrl [11] = '{8'h16, 8'h1B, 8'h1F, 8'h1B, 8'h1F, 8'h1B, 8'h17,
        8'h19, 8'h1D, 8'h19, 8'h19};
    logic [7:0] m_cmp [11] = '{8'h07, 8'h40, 8'h40, 8'hFF, 8'hFF, 8'h00, 8'h40,
        8'h40, 8'h40, 8'h00, 8'hFF};
    logic [15:0] m_exp [11] = '{16'h0100, 16'h0082, 16'h017E, 16'h0200, 16'h0000,
        16'h0002, 16'h0100, 16'h0100, 16'h02FC, 16'h0000, 16'h03FC};
    int div_tab [5] = '{1, 8, 64, 256, 1024};
    always #2.5 clk_sys = ~clk_sys;
    t8w_timer dut (.clk_sys(clk_sys), .reset(reset), .bus_req(bus_req), .rdata(rdata),
        .ext_count_pin(ext_count_pin), .pin_out(pin_out), .pin_oe(pin_oe),
        .compare_flag(compare_flag), .overflow_flag(overflow_flag));
    t8w_load load (.clk_sys(clk_sys), .pin_out(pin_out), .pin_oe(pin_oe),
        .count_en(count_en), .pin_level(pin_level), .high_cnt(high_cnt));
    // ======================================================================
    // Bus cycles, comparison, windows and verdict.
    task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys);
        bus_req <= '0;
        #1;
    endtask
    task automatic bus_rd(input logic [2:0] a);
        @(posedge clk_sys);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_sys);
        bus_req <= '0;
        #1 rd_val = rdata;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Starts from a stopped timer and stops it again w cycles later.
    task automatic run_for(input logic [7:0] ctrl, input int w);
        bus_wr(3'h0, ctrl);
        repeat (w - 2) @(posedge clk_sys);
        bus_wr(3'h0, {4'h0, ctrl[3:0]});
    endtask
    task automatic measure(input logic [15:0] exp, input int w);
        @(posedge clk_sys);
        count_en <= 1'b0;
        repeat (1600) @(posedge clk_sys);
        bus_wr(3'h3, 8'h03);
        count_en <= 1'b1;
        repeat (w) @(posedge clk_sys);
        #1 chk("high cycles", exp, high_cnt);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (80000) @(posedge clk_sys);
        err_total++;
        print_verdict();
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        for (int a = 0; a < 7; a++) begin
            bus_rd(a[2:0]);
            chk("reset or unmapped value", 16'h0000, {8'h00, rd_val});
        end
        bus_wr(3'h4, 8'h02);
        chk("released pin", 16'h0000, {15'h0000, pin_level});
        bus_wr(3'h4, 8'h03);
        chk("driven pin", 16'h0001, {15'h0000, pin_level});
        bus_wr(3'h2, 8'h03);
        run_for(8'h12, 6);
        bus_rd(3'h1);
        chk("count", 16'h0002, {8'h00, rd_val});
        chk("compare flag", 16'h0001, {15'h0000, compare_flag});
        chk("overflow flag", 16'h0000, {15'h0000, overflow_flag});
        bus_wr(3'h1, 8'h0A);
        bus_wr(3'h2, 8'h05);
        bus_wr(3'h3, 8'h03);
        run_for(8'h12, 250);
        bus_rd(3'h1);
        chk("count", 16'h0004, {8'h00, rd_val});
        chk("compare flag", 16'h0000, {15'h0000, compare_flag});
        chk("overflow flag", 16'h0001, {15'h0000, overflow_flag});
        for (int i = 0; i < 5; i++) begin
            bus_wr(3'h1, 8'h00);
            bus_wr(3'h2, 8'hFF);
            run_for({1'b0, 3'(i + 1), 4'h2}, 4 * div_tab[i]);
            bus_rd(3'h1);
            chk("prescaled count", 16'h0004, {8'h00, rd_val});
        end
        bus_wr(3'h4, 8'h01);
        for (int i = 0; i < 11; i++) begin
            bus_wr(3'h2, m_cmp[i]);
            bus_wr(3'h0, m_ctrl[i]);
            measure(m_exp[i], (m_ctrl[i][1:0] == 2'h1) ? 1020 : 512);
            chk("overflow flag", {15'h0000, i > 0}, {15'h0000, overflow_flag});
        end
        bus_wr(3'h0, 8'h0A);
        chk("wave before force", 16'h0001, {15'h0000, pin_level});
        bus_wr(3'h0, 8'h8A);
        chk("forced wave", 16'h0000, {15'h0000, pin_level});
        bus_wr(3'h0, 8'h11);
        bus_wr(3'h4, 8'h03);
        measure(16'h0200, 512);
        print_verdict();
    end
endmodule
